// ---- hdl/smap_pkg.sv ----
`default_nettype none
package smap_pkg;
    // register indices; byte address is four times the index
    localparam int unsigned ROUTE_IDX = 3;
    localparam int unsigned INCTRL_IDX = 4;
    localparam int unsigned VITAL_IDX = 21;
    localparam int unsigned IRQSTAT_IDX = 22;
    localparam int unsigned IRQMASK_IDX = 23;
    localparam logic [11:0] ROUTE_ADDR = 12'(ROUTE_IDX * 4);
    localparam logic [11:0] INCTRL_ADDR = 12'(INCTRL_IDX * 4);
    localparam logic [11:0] VITAL_ADDR = 12'(VITAL_IDX * 4);
    localparam logic [11:0] IRQSTAT_ADDR = 12'(IRQSTAT_IDX * 4);
    localparam logic [11:0] IRQMASK_ADDR = 12'(IRQMASK_IDX * 4);
    // route register: pin a enables at [12:10], pin b enables at [9:7]
    localparam int unsigned ROUTE_LSB = 7;
    localparam int unsigned ROUTE_A_LSB = 3;
    localparam int unsigned ROUTE_B_LSB = 0;
    // input control register fields
    localparam int unsigned SEC_EN_BIT = 5;
    localparam int unsigned AUTO_SW_BIT = 0;
    localparam int unsigned MAN_SEL_BIT = 1;
    localparam int unsigned STALL_MODE_BIT = 2;
    // vital bits in the vital register and in the event registers
    localparam int unsigned SEL_BIT = 0;
    localparam int unsigned LOSS_BIT = 1;
    localparam int unsigned UNLOCK_BIT = 2;
    // reset values
    localparam logic [5:0] ROUTE_RST = 6'h00;
    localparam logic SEC_EN_RST = 1'b1;
    localparam logic AUTO_SW_RST = 1'b0;
    localparam logic MAN_SEL_RST = 1'b0;
    localparam logic STALL_MODE_RST = 1'b0;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // loss and unlock start high so the first synced levels raise no event
    localparam logic [2:0] VIT_PREV_RST = 3'h6;
    // stalled loss engine: lock pin high for all but one of this many cycles
    localparam int unsigned STALL_PERIOD = 512;
    localparam logic [8:0] STALL_LAST = 9'(STALL_PERIOD - 1);

    typedef struct packed {
        logic pllUnlock;
        logic refLoss;
        logic selRef;
    } smap_vital_t;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [5:0] route;
        logic secEn;
        logic autoSw;
        logic manSel;
        logic stallMode;
        logic selRef;
        smap_vital_t vitPrev;
        logic [2:0] irqStat;
        logic [2:0] irqMask;
        logic [8:0] stallCnt;
        logic pinA;
        logic pinB;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } smap_state_t;
endpackage : smap_pkg
`default_nettype wire

// ---- hdl/smap_pin_mux.sv ----
`default_nettype none
module smap_pin_mux (
    input wire logic [2:0] enable,
    input wire smap_pkg::smap_vital_t vital,
    output logic pinLevel
);
    logic [2:0] pinVital;

    always_comb
    begin
        pinVital = {vital.selRef, vital.refLoss, ~vital.pllUnlock};
        pinLevel = |(enable & pinVital);
    end
endmodule : smap_pin_mux
`default_nettype wire

// ---- hdl/smap_status_mapper.sv ----
// Overview of operation
// - two status pins, six route enables
// - select vital: 0 primary, 1 secondary
// - loss vital high when reference lost
// - loss stuck high without secondary enable
// - unlock register bit high when unlocked
// - pin lock polarity inverted versus register
// - all three vitals readable by software
// - stalled engine: lock high 511/512
// - several enables on one pin OR
//
// Local design decisions: the APB slave port and the placing of the registers.
`default_nettype none
module smap_status_mapper (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primaryPresent,
    input wire logic secondaryPresent,
    input wire logic pllLocked,
    output logic statusOutA,
    output logic statusOutB,
    output logic irq
);
    smap_pkg::smap_state_t q;
    smap_pkg::smap_state_t d;
    smap_pkg::smap_vital_t vit;
    logic priOk;
    logic secOk;
    logic lockOk;
    logic bothStalled;
    logic pinADrive;
    logic pinBDrive;
    logic setup;
    logic wrAcc;
    logic [2:0] events;

    assign priOk = q.sync2[0];
    assign secOk = q.sync2[1];
    assign lockOk = q.sync2[2];
    assign bothStalled = q.autoSw && !priOk && !secOk;
    assign setup = psel && !penable;
    assign wrAcc = psel && penable && q.pready && pwrite;

    always_comb
    begin
        vit.selRef = q.selRef;
        vit.refLoss = q.secEn ? !(q.selRef ? secOk : priOk) : 1'b1;
        vit.pllUnlock = !lockOk;
        if (bothStalled && q.stallMode)
        begin
            vit.pllUnlock = (q.stallCnt == smap_pkg::STALL_LAST);
        end
    end

    smap_pin_mux muxA (
        .enable(q.route[smap_pkg::ROUTE_A_LSB +: 3]),
        .vital(vit),
        .pinLevel(pinADrive)
    );

    smap_pin_mux muxB (
        .enable(q.route[smap_pkg::ROUTE_B_LSB +: 3]),
        .vital(vit),
        .pinLevel(pinBDrive)
    );

    assign events = {vit.pllUnlock & ~q.vitPrev.pllUnlock,
                     vit.refLoss & ~q.vitPrev.refLoss,
                     vit.selRef ^ q.vitPrev.selRef};

    always_comb
    begin
        d = q;
        d.sync1 = {pllLocked, secondaryPresent, primaryPresent};
        d.sync2 = q.sync1;
        if (!q.secEn)
        begin
            d.selRef = 1'b0;
        end
        else if (!q.autoSw)
        begin
            d.selRef = q.manSel;
        end
        else if (!q.selRef && !priOk && secOk)
        begin
            d.selRef = 1'b1;
        end
        else if (q.selRef && !secOk && priOk)
        begin
            d.selRef = 1'b0;
        end
        d.stallCnt = (bothStalled && q.stallMode) ? q.stallCnt + 9'h001 : 9'h000;
        d.vitPrev = vit;
        d.pinA = pinADrive;
        d.pinB = pinBDrive;
        // register writes in the access phase
        if (wrAcc)
        begin
            if (paddr == smap_pkg::ROUTE_ADDR)
            begin
                d.route = pwdata[smap_pkg::ROUTE_LSB +: 6];
            end
            else if (paddr == smap_pkg::INCTRL_ADDR)
            begin
                d.secEn = pwdata[smap_pkg::SEC_EN_BIT];
                d.autoSw = pwdata[smap_pkg::AUTO_SW_BIT];
                d.manSel = pwdata[smap_pkg::MAN_SEL_BIT];
                d.stallMode = pwdata[smap_pkg::STALL_MODE_BIT];
            end
            else if (paddr == smap_pkg::IRQSTAT_ADDR)
            begin
                d.irqStat = q.irqStat & ~pwdata[2:0];
            end
            else if (paddr == smap_pkg::IRQMASK_ADDR)
            begin
                d.irqMask = pwdata[2:0];
            end
        end
        // new events win over a clear in the same cycle
        d.irqStat = d.irqStat | events;
        d.irq = |(q.irqStat & q.irqMask);
        // one wait-free answer: ready is registered from setup and rises in the access cycle after it
        d.pready = setup;
        d.pslverr = 1'b0;
        d.prdata = 32'h0000_0000;
        if (setup)
        begin
            if (paddr == smap_pkg::ROUTE_ADDR)
            begin
                d.prdata[smap_pkg::ROUTE_LSB +: 6] = q.route;
            end
            else if (paddr == smap_pkg::INCTRL_ADDR)
            begin
                d.prdata[smap_pkg::SEC_EN_BIT] = q.secEn;
                d.prdata[smap_pkg::AUTO_SW_BIT] = q.autoSw;
                d.prdata[smap_pkg::MAN_SEL_BIT] = q.manSel;
                d.prdata[smap_pkg::STALL_MODE_BIT] = q.stallMode;
            end
            else if (paddr == smap_pkg::VITAL_ADDR)
            begin
                d.prdata[smap_pkg::SEL_BIT] = vit.selRef;
                d.prdata[smap_pkg::LOSS_BIT] = vit.refLoss;
                d.prdata[smap_pkg::UNLOCK_BIT] = vit.pllUnlock;
            end
            else if (paddr == smap_pkg::IRQSTAT_ADDR)
            begin
                d.prdata[2:0] = q.irqStat;
            end
            else if (paddr == smap_pkg::IRQMASK_ADDR)
            begin
                d.prdata[2:0] = q.irqMask;
            end
            else
            begin
                d.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.route <= smap_pkg::ROUTE_RST;
            q.secEn <= smap_pkg::SEC_EN_RST;
            q.autoSw <= smap_pkg::AUTO_SW_RST;
            q.manSel <= smap_pkg::MAN_SEL_RST;
            q.stallMode <= smap_pkg::STALL_MODE_RST;
            q.irqStat <= smap_pkg::IRQ_RST;
            q.irqMask <= smap_pkg::IRQ_RST;
            q.vitPrev <= smap_pkg::VIT_PREV_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign statusOutA = q.pinA;
    assign statusOutB = q.pinB;
    assign irq = q.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    AST_PIN_ZERO_A: assert property (
        q.route[5:3] == 3'b000 |=> !statusOutA)
        else $error("pin a high with no enables");
    AST_PIN_ZERO_B: assert property (
        q.route[2:0] == 3'b000 |=> !statusOutB)
        else $error("pin b high with no enables");
    AST_SEL_ONLY: assert property (
        q.route[5:3] == 3'b100 |=> statusOutA == $past(q.selRef))
        else $error("pin a does not follow selection");
    AST_LOSS_STUCK: assert property (
        !q.secEn && q.route[1] |=> statusOutB)
        else $error("loss not held high without secondary");
    AST_LOSS_PRESENT: assert property (
        q.secEn && !q.selRef && priOk && q.route[2:0] == 3'b010 |=> !statusOutB)
        else $error("loss reported with reference present");
    AST_LOCK_POL: assert property (
        q.route[2:0] == 3'b001 && !vit.pllUnlock |=> statusOutB)
        else $error("lock pin polarity wrong");
    AST_UNLOCK_REG: assert property (
        !bothStalled |-> vit.pllUnlock == !q.sync2[2])
        else $error("unlock vital wrong");
    AST_OR_PIN: assert property (
        q.route[5:3] == 3'b110 |=> statusOutA == $past(vit.selRef | vit.refLoss))
        else $error("pin a not or of enables");
    AST_STALL_WRAP: assert property (
        bothStalled && q.stallMode && q.stallCnt == 9'h1FF |=> q.stallCnt == 9'h000)
        else $error("stall period not 512");
    AST_STALL_LOW: assert property (
        bothStalled && q.stallMode && q.stallCnt == 9'h000 |-> !vit.pllUnlock)
        else $error("stalled lock not high");
    AST_VITAL_READ: assert property (
        setup && paddr == smap_pkg::VITAL_ADDR |=> prdata[2:0] == $past(vit))
        else $error("vital readback wrong");
    AST_IRQ_LEVEL: assert property (
        |(q.irqStat & q.irqMask) |=> irq)
        else $error("irq not raised");
    AST_SEL_FORCED: assert property (
        !q.secEn |=> !q.selRef)
        else $error("selection not forced to primary");
    AST_MANUAL_SEL: assert property (
        q.secEn && !q.autoSw |=> q.selRef == $past(q.manSel))
        else $error("manual selection not followed");
    AST_AUTO_TO_SEC: assert property (
        q.secEn && q.autoSw && !q.selRef && !priOk && secOk |=> q.selRef)
        else $error("no switch to secondary");
    AST_AUTO_TO_PRI: assert property (
        q.secEn && q.autoSw && q.selRef && !secOk && priOk |=> !q.selRef)
        else $error("no switch to primary");
    AST_LOSS_SEC: assert property (
        q.secEn && q.selRef && !secOk && q.route[5:3] == 3'b010 |=> statusOutA)
        else $error("loss of secondary not reported");
    AST_LOSS_STUCK_A: assert property (
        !q.secEn && q.route[4] |=> statusOutA)
        else $error("loss on pin a not held high");
    AST_LOCK_POL_A: assert property (
        q.route[5:3] == 3'b001 && vit.pllUnlock |=> !statusOutA)
        else $error("pin a high while unlocked");
    AST_SEL_ONLY_B: assert property (
        q.route[2:0] == 3'b100 |=> statusOutB == $past(q.selRef))
        else $error("pin b does not follow selection");
    AST_OR_PIN_B: assert property (
        q.route[2:0] == 3'b111 |=> statusOutB == $past(q.selRef | vit.refLoss | !vit.pllUnlock))
        else $error("pin b not or of enables");
    AST_UNLOCK_SET: assert property (
        !q.stallMode && !lockOk |-> vit.pllUnlock)
        else $error("unlock vital low while unlocked");
    AST_STALL_LOSS: assert property (
        bothStalled |-> vit.refLoss)
        else $error("loss not high with both inputs stalled");
    AST_STALL_ONE_LOW: assert property (
        bothStalled && q.stallMode && q.stallCnt == smap_pkg::STALL_LAST |-> vit.pllUnlock)
        else $error("stalled lock never drops");
    AST_STALL_CLEAR: assert property (
        !(bothStalled && q.stallMode) |=> q.stallCnt == 9'h000)
        else $error("stall counter not cleared");
    AST_READY_SETUP: assert property (
        setup |=> pready)
        else $error("no ready after setup");
    AST_READY_IDLE: assert property (
        !setup |=> !pready)
        else $error("ready without setup");
    AST_SLVERR: assert property (
        pslverr |-> pready)
        else $error("error without ready");
    AST_READ_ZERO: assert property (
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    AST_IRQ_LOW: assert property (
        !(|(q.irqStat & q.irqMask)) |=> !irq)
        else $error("irq without unmasked event");
    AST_EVENT_SET: assert property (
        vit.pllUnlock && !q.vitPrev.pllUnlock |=> q.irqStat[smap_pkg::UNLOCK_BIT])
        else $error("unlock event not latched");
    AST_ROUTE_WRITE: assert property (
        wrAcc && paddr == smap_pkg::ROUTE_ADDR
        |=> q.route == $past(pwdata[smap_pkg::ROUTE_LSB +: 6]))
        else $error("route write lost");

    COV_SWITCH: cover property (q.autoSw && $rose(q.selRef));
    COV_STALL: cover property (bothStalled && q.stallMode && q.stallCnt == 9'h1FF);
    COV_OR: cover property (q.route[5:3] == 3'b111 && statusOutA);
    COV_IRQ: cover property ($rose(irq));
endmodule : smap_status_mapper
`default_nettype wire

// ---- test/smap_ref_model.sv ----
`default_nettype none
module smap_ref_model (
    input wire logic clk_sys,
    input wire logic [2:0] req,
    output var logic primaryPresent,
    output var logic secondaryPresent,
    output var logic pllLocked
);
    timeunit 1ns;
    timeprecision 1ps;
    // reference and lock levels move only just after a clock edge
    always @(posedge clk_sys)
        {pllLocked, secondaryPresent, primaryPresent} <= req;
endmodule : smap_ref_model
`default_nettype wire

// ---- test/smap_status_mapper_tb.sv ----
`default_nettype none
module smap_status_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic primaryPresent;
    logic secondaryPresent;
    logic pllLocked;
    logic statusOutA;
    logic statusOutB;
    logic irq;
    logic [2:0] req = 3'h7;
    logic [31:0] r;
    logic lastErr;
    int error_cnt = 0;
    int num_checks = 0;
    int lows;
    always #12.5 clk_sys = ~clk_sys;
    smap_status_mapper smap_status_mapper_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .primaryPresent(primaryPresent),
        .secondaryPresent(secondaryPresent), .pllLocked(pllLocked),
        .statusOutA(statusOutA), .statusOutB(statusOutB), .irq(irq));
    smap_ref_model smap_ref_model_i (.clk_sys(clk_sys), .req(req),
        .primaryPresent(primaryPresent), .secondaryPresent(secondaryPresent),
        .pllLocked(pllLocked));

    task automatic end_sim();
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            $display("Error pready expected 1 seen %b", pready);
            error_cnt++;
            end_sim();
        end
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, r);
    endtask : rd

    task automatic pins(input logic a, input logic b);
        repeat (5) @(posedge clk_sys);
        chk("pins", 32'({a, b}), 32'({statusOutA, statusOutB}));
    endtask : pins

    initial
    begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        pins(1'b0, 1'b0);
        rd(smap_pkg::ROUTE_ADDR, 32'h0000_0000, "route");
        rd(smap_pkg::INCTRL_ADDR, 32'h0000_0020, "inctrl");
        rd(smap_pkg::VITAL_ADDR, 32'h0000_0000, "vitals");
        rd(12'h0fc, 32'h0000_0000, "unmapped");
        chk("pslverr", 32'h0000_0001, 32'(lastErr));
        apb(1'b1, smap_pkg::ROUTE_ADDR, 32'h0000_1080);
        apb(1'b1, smap_pkg::INCTRL_ADDR, 32'h0000_0022);
        pins(1'b1, 1'b1);
        rd(smap_pkg::VITAL_ADDR, 32'h0000_0001, "vitals sel");
        apb(1'b1, smap_pkg::IRQMASK_ADDR, 32'h0000_0004);
        apb(1'b1, smap_pkg::IRQSTAT_ADDR, 32'h0000_0007);
        req <= 3'h3;
        pins(1'b1, 1'b0);
        rd(smap_pkg::VITAL_ADDR, 32'h0000_0005, "vitals unlock");
        chk("irq set", 32'h0000_0001, 32'(irq));
        apb(1'b1, smap_pkg::IRQSTAT_ADDR, 32'h0000_0004);
        repeat (3) @(posedge clk_sys);
        chk("irq clear", 32'h0000_0000, 32'(irq));
        req <= 3'h6;
        apb(1'b1, smap_pkg::ROUTE_ADDR, 32'h0000_0100);
        apb(1'b1, smap_pkg::INCTRL_ADDR, 32'h0000_0020);
        pins(1'b0, 1'b1);
        req <= 3'h7;
        pins(1'b0, 1'b0);
        apb(1'b1, smap_pkg::INCTRL_ADDR, 32'h0000_0000);
        pins(1'b0, 1'b1);
        apb(1'b1, smap_pkg::ROUTE_ADDR, 32'h0000_1400);
        apb(1'b1, smap_pkg::INCTRL_ADDR, 32'h0000_0020);
        pins(1'b1, 1'b0);
        apb(1'b1, smap_pkg::ROUTE_ADDR, 32'h0000_0080);
        apb(1'b1, smap_pkg::INCTRL_ADDR, 32'h0000_0025);
        req <= 3'h4;
        repeat (10) @(posedge clk_sys);
        lows = 0;
        repeat (512)
        begin
            @(posedge clk_sys);
            if (statusOutB !== 1'b1)
                lows++;
        end
        chk("stall lows", 32'h0000_0001, 32'(lows));
        apb(1'b0, smap_pkg::VITAL_ADDR, 32'h0000_0000);
        chk("stall loss", 32'h0000_0002, r & 32'h0000_0002);
        req <= 3'h2;
        apb(1'b1, smap_pkg::ROUTE_ADDR, 32'h0000_1380);
        pins(1'b1, 1'b1);
        rd(smap_pkg::VITAL_ADDR, 32'h0000_0005, "vitals auto");
        req <= 3'h5;
        repeat (2) @(posedge clk_sys);
        pins(1'b0, 1'b1);
        end_sim();
    end
endmodule : smap_status_mapper_tb
`default_nettype wire
